/* enc_consts.svh */
// Constants for the encoder pulse input scaler
`ifndef ENC_CONSTS_SVH
`define ENC_CONSTS_SVH
`define USE_NONE 2'h0
`define USE_FEEDBACK 2'h1
`define USE_REFERENCE 2'h2
`define SRC_AB 2'h0
`define SRC_A 2'h1
`define SRC_AB_INV 2'h2
`define PPR_DEFAULT 16'h0400
`define FILTER_MS_DEFAULT 16'h000A
`define PULSE_X1_DEFAULT 16'h0000
`define FREQ_Y1_DEFAULT 16'h0000
`define PULSE_X2_DEFAULT 16'h0064
`define FREQ_Y2_DEFAULT 16'h1770
`define PGAIN_DEFAULT 16'h0BB8
`define IGAIN_DEFAULT 16'h012C
`define SLIP_PCT_DEFAULT 16'h0064
`define METER_ADJ_DEFAULT 16'h0064
`define AUX1_DEFAULT 8'h00
`define AUX2_DEFAULT 8'h01
`define AUX3_DEFAULT 8'h02
`define CLK_HZ 100000000
`define GATE_MS 1
`define GATE_CYCLES (`CLK_HZ / 1000 * `GATE_MS)
`define PWM_STEPS 1000
`define ADDR_USE 4'h0
`define ADDR_SRC 4'h1
`define ADDR_PPR 4'h2
`define ADDR_FILT 4'h3
`define ADDR_X1 4'h4
`define ADDR_Y1 4'h5
`define ADDR_X2 4'h6
`define ADDR_Y2 4'h7
`define ADDR_PG 4'h8
`define ADDR_IG 4'h9
`define ADDR_SLIP 4'hA
`define ADDR_AUX 4'hB
`define ADDR_METER 4'hC
`define ADDR_DIR 4'hD
`define ADDR_FBF 4'hE
`define ADDR_REF 4'hF
`endif

/* enc_model.sv */
// Incremental A/B encoder model for the pulse input pins
`timescale 1ns/1ps
`default_nettype none
module enc_model #(
   parameter int PERIOD = 20
) (
   input wire logic clk_sys,
   input wire logic run,
   input wire logic reverse,
   output logic encA,
   output logic encB
);
   int phase = 0;
   // Shaft at rest holds both lines, as a real encoder does
   always_ff @(posedge clk_sys) begin
      if (run) begin
         phase <= (phase + 1) % PERIOD;
      end
   end
   assign encA = (phase < PERIOD / 2);
   assign encB = reverse ? (phase >= PERIOD * 3 / 4 || phase < PERIOD / 4) :
      (phase >= PERIOD / 4 && phase < PERIOD * 3 / 4);
endmodule
`default_nettype wire

/* enc_pkg.sv */
// Types shared by the encoder pulse input scaler
package enc_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   typedef struct packed {
      logic [15:0] outFreq;
      logic [15:0] maxFreq;
      logic [15:0] current;
      logic [15:0] ratedCurrent;
      logic [15:0] voltage;
      logic [15:0] maxVoltage;
      logic [15:0] dcLink;
      logic [15:0] maxDcLink;
      logic [15:0] ratedSlip;
   } drive_meas_s;
   typedef enum logic [1:0] {METER_FREQ = 2'h0, METER_CURR = 2'h1, METER_VOLT = 2'h2,
      METER_DCLINK = 2'h3} meter_mode_e;
endpackage

/* encoder_pulse_input_scaler.sv */
// Encoder pulse input: feedback, reference curve, aux outputs, load meter
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "enc_consts.svh"
// How it works
// - Usage none: encoder pulses affect neither feedback nor reference.
// - Usage feedback: pulse rate is speed feedback for a PI loop.
// - Usage reference: pulse-derived command replaces the main source.
// - Feedback mode with board fitted: report measured rotation direction.
// - Feedback mode with board fitted: report measured feedback frequency.
// - Source select: A+B (code 0), single channel, or inverted A+B.
// - Speed scaled by pulses-per-revolution, default 1024.
// - Reference mode low-pass filter, time constant default 10 ms.
// - Minimum pulse frequency maps to minimum output frequency.
// - Maximum pulse 10.0 kHz maps to maximum output 60.00 Hz.
// - Curve defined by two pulse breakpoints and two output frequencies.
// - Feedback PI proportional gain, default 3000.
// - Feedback PI integral gain, default 300.
// - Slip compensation limited to percent of rated slip, default 100.
// - Three open-collector aux outputs, functions from the aux contact list.
// - Aux outputs default to frequency detection one, two, three.
// - Load meter shows freq, current, voltage or DC link as pulse average.
// - Load meter scaled by adjustment percent, default 100.
// - Frequency mode: duty = fout/fmax times adjust/100.
module encoder_pulse_input_scaler
   import enc_pkg::*;
#(
   parameter int GATE_CYCLES = `GATE_CYCLES,
   parameter int PWM_STEPS = `PWM_STEPS
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire enc_pkg::reg_req_s regReq,
   output logic [15:0] regRdata,
   input wire logic encA,
   input wire logic encB,
   input wire logic boardFitted,
   input wire enc_pkg::drive_meas_s meas,
   input wire logic [15:0] speedCmd,
   input wire logic [15:0] mainFreqSource,
   input wire logic [31:0] auxFuncStatus,
   output logic [15:0] freqCommand,
   output logic [15:0] speedComp,
   output logic [2:0] auxOutOe,
   output logic [2:0] auxOutO,
   output logic loadMeterOut
);
   import enc_pkg::*;
   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [1:0] use_reg;
   logic [1:0] src_reg;
   logic [15:0] ppr_reg, filt_reg, x1_reg, y1_reg, x2_reg, y2_reg;
   logic [15:0] pg_reg, ig_reg, slip_reg, meterAdj_reg;
   logic [7:0] aux1_reg, aux2_reg, aux3_reg;
   meter_mode_e meterMode_reg;
   logic dir_reg;
   logic [15:0] fbFreq_reg, refFilt_reg;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         use_reg <= `USE_NONE;
         src_reg <= `SRC_AB;
         ppr_reg <= `PPR_DEFAULT;
         filt_reg <= `FILTER_MS_DEFAULT;
         x1_reg <= `PULSE_X1_DEFAULT;
         y1_reg <= `FREQ_Y1_DEFAULT;
         x2_reg <= `PULSE_X2_DEFAULT;
         y2_reg <= `FREQ_Y2_DEFAULT;
         pg_reg <= `PGAIN_DEFAULT;
         ig_reg <= `IGAIN_DEFAULT;
         slip_reg <= `SLIP_PCT_DEFAULT;
         aux1_reg <= `AUX1_DEFAULT;
         aux2_reg <= `AUX2_DEFAULT;
         aux3_reg <= `AUX3_DEFAULT;
         meterAdj_reg <= `METER_ADJ_DEFAULT;
         meterMode_reg <= METER_FREQ;
      end else if (regReq.wr) begin
         unique case (regReq.addr)
            `ADDR_USE: use_reg <= regReq.wdata[1:0];
            `ADDR_SRC: src_reg <= regReq.wdata[1:0];
            `ADDR_PPR: ppr_reg <= regReq.wdata;
            `ADDR_FILT: filt_reg <= regReq.wdata;
            `ADDR_X1: x1_reg <= regReq.wdata;
            `ADDR_Y1: y1_reg <= regReq.wdata;
            `ADDR_X2: x2_reg <= regReq.wdata;
            `ADDR_Y2: y2_reg <= regReq.wdata;
            `ADDR_PG: pg_reg <= regReq.wdata;
            `ADDR_IG: ig_reg <= regReq.wdata;
            `ADDR_SLIP: slip_reg <= regReq.wdata;
            `ADDR_AUX: begin
               aux1_reg <= {3'h0, regReq.wdata[4:0]};
               aux2_reg <= {3'h0, regReq.wdata[9:5]};
               aux3_reg <= {3'h0, regReq.wdata[14:10]};
            end
            `ADDR_METER: begin
               meterAdj_reg <= {2'h0, regReq.wdata[13:0]};
               meterMode_reg <= meter_mode_e'(regReq.wdata[15:14]);
            end
            default: begin
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdata <= 16'h0000;
      end else if (regReq.rd) begin
         unique case (regReq.addr)
            `ADDR_USE: regRdata <= {14'h0000, use_reg};
            `ADDR_SRC: regRdata <= {14'h0000, src_reg};
            `ADDR_PPR: regRdata <= ppr_reg;
            `ADDR_FILT: regRdata <= filt_reg;
            `ADDR_X1: regRdata <= x1_reg;
            `ADDR_Y1: regRdata <= y1_reg;
            `ADDR_X2: regRdata <= x2_reg;
            `ADDR_Y2: regRdata <= y2_reg;
            `ADDR_PG: regRdata <= pg_reg;
            `ADDR_IG: regRdata <= ig_reg;
            `ADDR_SLIP: regRdata <= slip_reg;
            `ADDR_AUX: regRdata <= {1'b0, aux3_reg[4:0], aux2_reg[4:0], aux1_reg[4:0]};
            `ADDR_METER: regRdata <= {meterMode_reg, meterAdj_reg[13:0]};
            `ADDR_DIR: regRdata <= {15'h0000, dir_reg};
            `ADDR_FBF: regRdata <= fbFreq_reg;
            `ADDR_REF: regRdata <= refFilt_reg;
            default: regRdata <= 16'h0000;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end
   // ----------------------------------------------------------------
   // Pin synchronisers and quadrature decode
   // ----------------------------------------------------------------
   logic [1:0] aSync_reg, bSync_reg;
   logic aPrev_reg, bPrev_reg;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aSync_reg <= 2'h0;
         bSync_reg <= 2'h0;
         aPrev_reg <= 1'b0;
         bPrev_reg <= 1'b0;
      end else begin
         aSync_reg <= {aSync_reg[0], encA};
         bSync_reg <= {bSync_reg[0], encB};
         aPrev_reg <= aSync_reg[1];
         bPrev_reg <= bSync_reg[1];
      end
   end
   logic aRise, quadFwd, countEvt;
   assign aRise = aSync_reg[1] & ~aPrev_reg;
   // phase order: B low at A rising means A leads
   assign quadFwd = ~bSync_reg[1];
   // single channel counts every A rise, paired modes too (x1 decode)
   assign countEvt = aRise;
   // ----------------------------------------------------------------
   // Gate-time frequency measurement, units of 0.1 kHz per count window
   // ----------------------------------------------------------------
   logic [31:0] gate_reg;
   logic [15:0] pulseCnt_reg, pulseHz100_reg;
   logic gateTick;
   assign gateTick = (gate_reg == 32'(GATE_CYCLES - 1));
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         gate_reg <= 32'h0000_0000;
         pulseCnt_reg <= 16'h0000;
         pulseHz100_reg <= 16'h0000;
      end else begin
         gate_reg <= gateTick ? 32'h0000_0000 : gate_reg + 32'h0000_0001;
         if (gateTick) begin
            // Pulses per 1 ms times 10 gives 0.1 kHz units; per 1 ms is kHz
            pulseHz100_reg <= 16'((32'(pulseCnt_reg) * 32'd10));
            pulseCnt_reg <= {15'h0000, countEvt};
         end else if (countEvt) begin
            pulseCnt_reg <= pulseCnt_reg + 16'h0001;
         end
      end
   end
   // ----------------------------------------------------------------
   // Direction and feedback frequency (0.01 Hz units)
   // ----------------------------------------------------------------
   logic fbActive;
   assign fbActive = boardFitted && (use_reg == `USE_FEEDBACK);
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dir_reg <= 1'b0;
         fbFreq_reg <= 16'h0000;
      end else if (!fbActive) begin
         // pulses ignored when not in feedback
         dir_reg <= 1'b0;
         fbFreq_reg <= 16'h0000;
      end else begin
         // direction reported, inverted for opposite mounting
         if (src_reg == `SRC_A) begin
            // One line alone cannot tell direction, so report none
            dir_reg <= 1'b0;
         end else if (aRise) begin
            dir_reg <= (src_reg == `SRC_AB_INV) ? ~quadFwd : quadFwd;
         end
         // feedback frequency = pulses/s / ppr, in 0.01 Hz
         if (gateTick && ppr_reg != 16'h0000) begin
            fbFreq_reg <= 16'((32'(pulseCnt_reg) * 32'd100000) / 32'(ppr_reg));
         end
      end
   end
   // ----------------------------------------------------------------
   // PI speed loop with slip-limited compensation
   // ----------------------------------------------------------------
   logic signed [31:0] integ_reg;
   logic signed [31:0] err, piSum, slipLim;
   always_comb begin
      err = 32'(signed'({1'b0, speedCmd})) - 32'(signed'({1'b0, fbFreq_reg}));
      // PI terms, scaled down to keep gains in integer form
      piSum = (err * 32'(signed'({1'b0, pg_reg}))) / 32'sd1000 + integ_reg / 32'sd1000;
      // limit = slip% of rated motor slip
      slipLim = 32'((32'(meas.ratedSlip) * 32'(slip_reg)) / 32'd100);
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !fbActive) begin
         // loop runs only in feedback mode
         integ_reg <= 32'sh0000_0000;
         speedComp <= 16'h0000;
      end else if (gateTick) begin
         if (piSum > -slipLim && piSum < slipLim) begin
            integ_reg <= integ_reg + err * 32'(signed'({1'b0, ig_reg}));
         end
         // clamp, negative compensation floored at zero
         if (piSum >= slipLim) begin
            speedComp <= slipLim[15:0];
         end else if (piSum <= 32'sh0) begin
            speedComp <= 16'h0000;
         end else begin
            speedComp <= piSum[15:0];
         end
      end
   end
   // ----------------------------------------------------------------
   // Reference curve and filter
   // ----------------------------------------------------------------
   logic [15:0] curveOut;
   logic [31:0] span;
   always_comb begin
      span = 32'h0;
      if (pulseHz100_reg <= x1_reg || x2_reg <= x1_reg) begin
         curveOut = y1_reg;
      end else if (pulseHz100_reg >= x2_reg) begin
         curveOut = y2_reg;
      end else begin
         span = 32'(pulseHz100_reg - x1_reg) * 32'(y2_reg - y1_reg);
         curveOut = y1_reg + 16'(span / 32'(x2_reg - x1_reg));
      end
   end
   logic [31:0] filtAcc_reg;
   logic [31:0] tauMs;
   assign tauMs = (filt_reg == 16'h0000) ? 32'd1 : 32'(filt_reg);
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         filtAcc_reg <= 32'h0;
         refFilt_reg <= 16'h0000;
      end else if (use_reg != `USE_REFERENCE) begin
         filtAcc_reg <= 32'h0;
         refFilt_reg <= 16'h0000;
      end else if (gateTick) begin
         // first-order lag, one step per 1 ms gate
         filtAcc_reg <= filtAcc_reg + 32'(curveOut) - filtAcc_reg / tauMs;
         refFilt_reg <= 16'(filtAcc_reg / tauMs);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         freqCommand <= 16'h0000;
      end else begin
         freqCommand <= (use_reg == `USE_REFERENCE) ? refFilt_reg : mainFreqSource;
      end
   end
   // ----------------------------------------------------------------
   // Open-collector aux outputs
   // ----------------------------------------------------------------
   logic [7:0] auxSel [3];
   assign auxSel[0] = aux1_reg;
   assign auxSel[1] = aux2_reg;
   assign auxSel[2] = aux3_reg;
   assign auxOutO = 3'h0;
   generate
      for (genvar i = 0; i < 3; i++) begin : g_aux
         // open collector: pull low only when active
         always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
               auxOutOe[i] <= 1'b0;
            end else begin
               auxOutOe[i] <= auxFuncStatus[auxSel[i][4:0]];
            end
         end
      end
   endgenerate
   // ----------------------------------------------------------------
   // Load meter
   // ----------------------------------------------------------------
   logic [15:0] meterNum, meterDen;
   logic [31:0] meterDuty;
   logic [15:0] meterDutySat;
   always_comb begin
      unique case (meterMode_reg)
         METER_FREQ: begin meterNum = meas.outFreq; meterDen = meas.maxFreq; end
         METER_CURR: begin meterNum = meas.current; meterDen = meas.ratedCurrent; end
         METER_VOLT: begin meterNum = meas.voltage; meterDen = meas.maxVoltage; end
         METER_DCLINK: begin meterNum = meas.dcLink; meterDen = meas.maxDcLink; end
      endcase
      // duty = num/den * steps * adj/100
      if (meterDen == 16'h0000) begin
         meterDuty = 32'h0;
      end else begin
         meterDuty = (32'(meterNum) * 32'(PWM_STEPS)) / 32'(meterDen);
         meterDuty = meterDuty * 32'(meterAdj_reg) / 32'd100;
      end
      meterDutySat = (meterDuty > 32'(PWM_STEPS)) ? 16'(PWM_STEPS) : meterDuty[15:0];
   end
   lm_pwm #(.STEPS(PWM_STEPS)) u_meter (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .duty(meterDutySat),
      .pwmOut(loadMeterOut)
   );
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_REF_SELECT: assert property (@(posedge clk_sys) disable iff (sys_rst)
      use_reg == `USE_REFERENCE |=> freqCommand == $past(refFilt_reg))
      else $error("reference not selected");
   AST_NONE_IGNORES: assert property (@(posedge clk_sys) disable iff (sys_rst)
      use_reg == `USE_NONE |=> fbFreq_reg == 16'h0000 && speedComp == 16'h0000)
      else $error("pulses used in none mode");
   AST_SLIP_LIMIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ##1 32'(speedComp) <= $past(slipLim) || !$past(gateTick))
      else $error("compensation above slip limit");
   AST_CURVE_LOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pulseHz100_reg <= x1_reg |-> curveOut == y1_reg)
      else $error("curve low end wrong");
   AST_CURVE_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pulseHz100_reg >= x2_reg && x2_reg > x1_reg |-> curveOut == y2_reg)
      else $error("curve high end wrong");
   AST_DIR_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !fbActive |=> !dir_reg)
      else $error("direction set outside feedback");
   AST_AUX_OC: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ##1 auxOutO == 3'h0 && auxOutOe[0] == $past(auxFuncStatus[aux1_reg[4:0]]))
      else $error("aux output not following its function");
   AST_METER_BOUND: assert property (@(posedge clk_sys) disable iff (sys_rst)
      32'(meterDutySat) <= 32'(PWM_STEPS))
      else $error("load meter duty out of range");
   COV_REF: cover property (@(posedge clk_sys) use_reg == `USE_REFERENCE && gateTick);
   COV_FB: cover property (@(posedge clk_sys) fbActive && speedComp != 16'h0000);
   COV_AUX: cover property (@(posedge clk_sys) auxOutOe != 3'h0);
endmodule
`default_nettype wire

/* lm_pwm.sv */
// Pulse-averaged load meter output generator
`timescale 1ns/1ps
`default_nettype none
module lm_pwm #(
   parameter int STEPS = 1000
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [15:0] duty,
   output logic pwmOut
);
   logic [15:0] cnt_reg;
   logic [15:0] dutyLatch_reg;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_reg <= 16'h0000;
         dutyLatch_reg <= 16'h0000;
      end else if (cnt_reg == 16'(STEPS - 1)) begin
         cnt_reg <= 16'h0000;
         dutyLatch_reg <= duty;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   // Duty latched per period so the average never tears mid-period
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pwmOut <= 1'b0;
      end else begin
         pwmOut <= (cnt_reg < dutyLatch_reg);
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the encoder pulse input scaler
`timescale 1ns/1ps
`default_nettype none
`include "enc_consts.svh"
module testbench;
   import enc_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   reg_req_s regReq = '0;
   drive_meas_s meas = '0;
   logic encA, encB, loadMeterOut;
   logic encRun = 1'b0;
   logic encRev = 1'b0;
   logic boardFitted = 1'b0;
   logic [15:0] speedCmd = 16'h0000;
   logic [15:0] mainFreqSource = 16'h1234;
   logic [31:0] auxFuncStatus = 32'h0000_0000;
   logic [15:0] regRdata, freqCommand, speedComp;
   logic [2:0] auxOutOe, auxOutO;
   int errTotal = 0;
   int checkCount = 0;
   int cycles = 0;
   logic [15:0] dflt [13] = '{16'h0000, 16'h0000, 16'h0400, 16'h000A, 16'h0000, 16'h0000,
      16'h0064, 16'h1770, 16'h0BB8, 16'h012C, 16'h0064, 16'h0820, 16'h0064};

   always #5 clk_sys = ~clk_sys;

   enc_model em (.clk_sys(clk_sys), .run(encRun), .reverse(encRev), .encA(encA), .encB(encB));

   encoder_pulse_input_scaler #(.GATE_CYCLES(100), .PWM_STEPS(20)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
      .encA(encA), .encB(encB), .boardFitted(boardFitted), .meas(meas),
      .speedCmd(speedCmd), .mainFreqSource(mainFreqSource), .auxFuncStatus(auxFuncStatus),
      .freqCommand(freqCommand), .speedComp(speedComp), .auxOutOe(auxOutOe),
      .auxOutO(auxOutO), .loadMeterOut(loadMeterOut));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic end_of_test();
      if (errTotal == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Limit covers every scenario with ample margin
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         errTotal++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         errTotal++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      regReq.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      regReq.rd <= 1'b0;
      @(negedge clk_sys);
      chk(regRdata, exp);
      @(posedge clk_sys);
   endtask

   task automatic meterchk(input logic [15:0] exp);
      int n;
      n = 0;
      wt(60);
      repeat (40) begin
         @(posedge clk_sys);
         #1 if (loadMeterOut === 1'b1) n++;
      end
      chk(16'(n), exp);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_defaults();
      for (int i = 0; i < 13; i++) begin
         rdchk(4'(i), dflt[i]);
      end
   endtask

   task automatic test_none();
      boardFitted <= 1'b1;
      encRun <= 1'b1;
      wt(300);
      chk(freqCommand, 16'h1234);
      chk(speedComp, 16'h0000);
      rdchk(`ADDR_FBF, 16'h0000);
      rdchk(`ADDR_DIR, 16'h0000);
      rdchk(`ADDR_REF, 16'h0000);
   endtask

   task automatic test_feedback();
      boardFitted <= 1'b1;
      wr(`ADDR_PPR, 16'h03E8);
      wr(`ADDR_USE, 16'(`USE_FEEDBACK));
      wt(300);
      rdchk(`ADDR_DIR, 16'h0001);
      rdchk(`ADDR_FBF, 16'h01F4);
      wr(`ADDR_FBF, 16'h0000);
      rdchk(`ADDR_FBF, 16'h01F4);
      encRev <= 1'b1;
      wt(300);
      rdchk(`ADDR_DIR, 16'h0000);
      wr(`ADDR_SRC, 16'(`SRC_AB_INV));
      wt(300);
      rdchk(`ADDR_DIR, 16'h0001);
      wr(`ADDR_SRC, 16'(`SRC_A));
      wt(300);
      rdchk(`ADDR_DIR, 16'h0000);
      encRev <= 1'b0;
      wr(`ADDR_SRC, 16'(`SRC_AB));
   endtask

   // Large speed error drives the PI output into the slip limit
   task automatic test_slip();
      meas.ratedSlip <= 16'h00C8;
      speedCmd <= 16'h0FA0;
      wr(`ADDR_SLIP, 16'h0032);
      wt(1000);
      chk(speedComp, 16'h0064);
      // Small error with no integral term shows the bare proportional gain
      wr(`ADDR_IG, 16'h0000);
      speedCmd <= 16'h01FE;
      wt(300);
      chk(speedComp, 16'h001E);
      wr(`ADDR_IG, 16'h012C);
      wt(3000);
      chk(speedComp, 16'h0064);
   endtask

   task automatic test_reference();
      mainFreqSource <= 16'h2222;
      wr(`ADDR_FILT, 16'h0001);
      wr(`ADDR_USE, 16'(`USE_REFERENCE));
      wt(500);
      chk(freqCommand, 16'h0BB8);
      rdchk(`ADDR_REF, 16'h0BB8);
      wr(`ADDR_X2, 16'h0028);
      wt(500);
      chk(freqCommand, 16'h1770);
      wr(`ADDR_X2, 16'h0064);
      wr(`ADDR_X1, 16'h0032);
      wr(`ADDR_Y1, 16'h03E8);
      wt(500);
      chk(freqCommand, 16'h03E8);
   endtask

   task automatic test_aux();
      auxFuncStatus <= 32'h0000_0005;
      wt(5);
      chk({13'h0000, auxOutOe}, 16'h0005);
      chk({13'h0000, auxOutO}, 16'h0000);
      wr(`ADDR_AUX, 16'h0827);
      auxFuncStatus <= 32'h0000_0080;
      wt(5);
      chk({13'h0000, auxOutOe}, 16'h0001);
   endtask

   task automatic test_meter();
      meas.outFreq <= 16'h0BB8;
      meas.maxFreq <= 16'h1770;
      meas.current <= 16'h0019;
      meas.ratedCurrent <= 16'h0064;
      meas.voltage <= 16'h0190;
      meas.maxVoltage <= 16'h0190;
      meas.dcLink <= 16'h012C;
      meas.maxDcLink <= 16'h0190;
      meterchk(16'h0014);
      wr(`ADDR_METER, 16'h0032);
      meterchk(16'h000A);
      wr(`ADDR_METER, 16'h4064);
      meterchk(16'h000A);
      wr(`ADDR_METER, 16'h8064);
      meterchk(16'h0028);
      wr(`ADDR_METER, 16'hC064);
      meterchk(16'h001E);
   endtask

   initial begin
      wt(20);
      sys_rst <= 1'b0;
      test_defaults();
      test_none();
      test_feedback();
      test_slip();
      test_reference();
      test_aux();
      test_meter();
      end_of_test();
   end
endmodule
`default_nettype wire
